// [logic/ppei_params.svh]
// Constants for the port pin edge interrupt block.
`ifndef PPEI_PARAMS_SVH
`define PPEI_PARAMS_SVH
`define PPEI_NPORT 6
`define PPEI_NIRQ 3
`define PPEI_PORT_T 0
`define PPEI_PORT_S 1
`define PPEI_PORT_M 2
`define PPEI_PORT_P 3
`define PPEI_PORT_H 4
`define PPEI_PORT_J 5
`define PPEI_IRQ_P 0
`define PPEI_IRQ_H 1
`define PPEI_IRQ_J 2
`define PPEI_FULL_MASK 8'hFF
`define PPEI_NONE_MASK 8'h00
`define PPEI_PORT_J_MASK 8'hC3
`define PPEI_RST_PULL_S 8'hFF
`define PPEI_RST_PULL_J 8'hC3
`define PPEI_FILT_SAMPLES 3'h4
`define PPEI_CNT_ONE 3'h1
`define PPEI_CNT_MAX 3'h5
`define PPEI_RC_DIV 4'h4
`define PPEI_RC_ONE 4'h1
`define PPEI_SCI_A_LSB 0
`define PPEI_SCI_B_LSB 2
`define PPEI_SPI_A_LSB 4
`define PPEI_SPI_A_ALT_LSB 2
`define PPEI_SPI_B_LSB 0
`define PPEI_PWM_IN_BIT 7
`define PPEI_SCL_BIT 7
`define PPEI_SDA_BIT 6
`endif

// [logic/ppei_pkg.sv]
// Types shared by the port pin edge interrupt block.
`default_nettype none
package ppei_pkg;
   typedef enum logic [1:0] {mode_run, mode_wait, mode_stop} ppei_mode_e;
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] rdrive;
      logic [7:0] pull_en;
      logic [7:0] polarity;
      logic [7:0] irq_en;
   } ppei_cfg_s;
   typedef struct packed {
      logic [7:0] own;
      logic [7:0] o;
      logic [7:0] oe;
      logic [7:0] od;
   } ppei_ovr_s;
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
      logic [7:0] pu;
      logic [7:0] pd;
      logic [7:0] rd;
   } ppei_pad_s;
   typedef struct packed {
      logic [2:0] cnt;
      logic       last;
      logic       armed;
      logic       hit;
   } ppei_filt_s;
endpackage
`default_nettype wire

// [logic/ppei_glitch_filter.sv]
// Per-pin glitch filter that reports qualified active edges.
`timescale 1ns/10ps
`default_nettype none
`include "ppei_params.svh"
module ppei_glitch_filter
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Sampling
   input  wire logic sample_en,
   input  wire logic level,
   input  wire logic polarity,
   // Result
   output logic      edge_o,
   output logic      busy
);
   import ppei_pkg::*;
   ppei_filt_s state_q;
   ppei_filt_s state_d;
   logic       act;

   assign act = ~(level ^ polarity);

   // Counts equal samples; arms on passive run, fires on active run.
   always_comb
   begin
      state_d = state_q;
      state_d.hit = 1'b0;
      if (sample_en)
      begin
         if (act != state_q.last)
         begin
            state_d.last = act;
            state_d.cnt = `PPEI_CNT_ONE;
         end
         else if (state_q.cnt != `PPEI_CNT_MAX)
         begin
            state_d.cnt = state_q.cnt + `PPEI_CNT_ONE;
         end
         if (!act && state_d.cnt >= `PPEI_FILT_SAMPLES)
         begin
            state_d.armed = 1'b1;
         end
         if (act && state_q.armed && state_d.cnt >= `PPEI_FILT_SAMPLES)
         begin
            state_d.hit = 1'b1;
            state_d.armed = 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign edge_o = state_q.hit;
   // A level that differs from the last sample, or a run of four samples or fewer, counts as busy; a settled pin lets the oscillator stop.
   assign busy = (state_q.cnt <= `PPEI_FILT_SAMPLES) || (act != state_q.last);

   AST_FILT_FOUR_ACTIVE: assert property (@(posedge clk) disable iff (reset)
      edge_o && $past(sample_en, 1) && $past(sample_en, 2) && $past(sample_en, 3)
      && $past(sample_en, 4) |-> $past(act, 1) && $past(act, 2) && $past(act, 3)
      && $past(act, 4))
      else $error("Edge reported without four active samples.");
   AST_FILT_ARMED: assert property (@(posedge clk) disable iff (reset)
      edge_o |-> $past(state_q.armed) && !state_q.armed)
      else $error("Edge reported without a prior passive run.");
endmodule
`default_nettype wire

// [logic/ppei_pad_ctrl.sv]
// Pin driver, pull and read-back control for one 8-pin port.
`timescale 1ns/10ps
`default_nettype none
`include "ppei_params.svh"
module ppei_pad_ctrl
#(
   parameter logic [7:0] IMPL = `PPEI_FULL_MASK
)
(
   // Configuration and peripheral override
   input  wire ppei_pkg::ppei_cfg_s cfg,
   input  wire ppei_pkg::ppei_ovr_s ovr,
   input  wire logic [7:0]          level,
   // Pad controls and read-back
   output ppei_pkg::ppei_pad_s      pad,
   output logic [7:0]               rd_io
);
   import ppei_pkg::*;
   logic [7:0] oe;
   logic [7:0] od;
   logic [7:0] pp_out;

   // A peripheral that owns a pin overrides the direction bit.
   assign od = ovr.own & ovr.od;
   assign oe = (ovr.own & ~od & ovr.oe) | (od & ~ovr.o) | (~ovr.own & cfg.dir);
   assign pp_out = oe & ~od;

   always_comb
   begin
      pad.o = IMPL & ((ovr.own & ~od & ovr.o) | (~ovr.own & cfg.data));
      pad.oe = IMPL & oe;
      pad.pu = IMPL & cfg.pull_en & ~cfg.polarity & ~pp_out;
      pad.pd = IMPL & cfg.pull_en & cfg.polarity & ~oe & ~od;
      pad.rd = IMPL & cfg.rdrive & oe;
   end

   assign rd_io = IMPL & ((cfg.dir & cfg.data) | (~cfg.dir & level));
endmodule
`default_nettype wire

// [logic/ppei_top.sv]
// Port integration logic with filtered pin edge interrupts.
`timescale 1ns/10ps
`default_nettype none
`include "ppei_params.svh"
module ppei_top
(
   // Clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 reset,
   // Power mode
   input  wire ppei_pkg::ppei_mode_e                 mode,
   // Port configuration writes
   input  wire logic [`PPEI_NPORT-1:0]               cfg_wr,
   input  wire ppei_pkg::ppei_cfg_s                  cfg_wdata,
   input  wire logic [`PPEI_NIRQ-1:0][7:0]           flag_clr,
   // Routing
   input  wire logic                                 route_spi_a,
   input  wire logic                                 route_spi_b,
   // Capture timer and async serial units
   input  wire logic [7:0]                           timer_en,
   input  wire logic [7:0]                           timer_out,
   input  wire logic                                 sci_a_en,
   input  wire logic                                 sci_b_en,
   input  wire logic [3:0]                           sci_out,
   input  wire logic [3:0]                           sci_oe,
   // Serial-peripheral units
   input  wire logic                                 spi_a_en,
   input  wire logic [3:0]                           spi_a_out,
   input  wire logic [3:0]                           spi_a_oe,
   input  wire logic                                 spi_b_en,
   input  wire logic [3:0]                           spi_b_out,
   input  wire logic [3:0]                           spi_b_oe,
   // Modulator and two-wire controller
   input  wire logic                                 pwm_en,
   input  wire logic                                 pwm7_input,
   input  wire logic [7:0]                           pwm_out,
   input  wire logic                                 i2c_en,
   input  wire logic                                 i2c_scl_o,
   input  wire logic                                 i2c_sda_o,
   // Pins
   input  wire logic [`PPEI_NPORT-1:0][7:0]          pin_i,
   output ppei_pkg::ppei_pad_s [`PPEI_NPORT-1:0]     pad,
   // Read-back and peripheral inputs
   output logic [`PPEI_NPORT-1:0][7:0]               io_read,
   output logic [`PPEI_NPORT-1:0][7:0]               pin_level,
   output logic [3:0]                                spi_a_in,
   output logic [3:0]                                spi_b_in,
   // Interrupts and wake-up
   output logic [`PPEI_NIRQ-1:0][7:0]                flags,
   output logic [`PPEI_NIRQ-1:0]                     irq,
   output logic                                      wake,
   output logic                                      rc_osc_run
);
   import ppei_pkg::*;

   typedef struct packed {
      ppei_cfg_s [`PPEI_NPORT-1:0]   cfg;
      logic [`PPEI_NPORT-1:0][7:0]   sync1;
      logic [`PPEI_NPORT-1:0][7:0]   sync2;
      logic [`PPEI_NIRQ-1:0][7:0]    flag;
      logic [3:0]                    rc_cnt;
      logic                          rc_tick;
   } ppei_state_s;

   localparam logic [`PPEI_NIRQ-1:0][7:0] IRQ_IMPL =
      {`PPEI_PORT_J_MASK, `PPEI_FULL_MASK, `PPEI_FULL_MASK};
   localparam int IRQ_PORT [`PPEI_NIRQ] = '{`PPEI_PORT_P, `PPEI_PORT_H, `PPEI_PORT_J};

   ppei_state_s                        state_q;
   ppei_state_s                        state_d;
   ppei_ovr_s [`PPEI_NPORT-1:0]        ovr;
   logic [`PPEI_NIRQ-1:0][7:0]         edge_hit;
   logic [`PPEI_NIRQ-1:0][7:0]         busy;
   logic [`PPEI_NIRQ-1:0][7:0]         waiting;
   logic                               sample_en;

   // Peripheral ownership of pins, per port.
   always_comb
   begin
      ovr = '0;
      ovr[`PPEI_PORT_T].own = timer_en;
      ovr[`PPEI_PORT_T].o = timer_out;
      ovr[`PPEI_PORT_T].oe = timer_en;
      if (sci_a_en)
      begin
         ovr[`PPEI_PORT_S].own[`PPEI_SCI_A_LSB +: 2] = 2'h3;
         ovr[`PPEI_PORT_S].o[`PPEI_SCI_A_LSB +: 2] = sci_out[1:0];
         ovr[`PPEI_PORT_S].oe[`PPEI_SCI_A_LSB +: 2] = sci_oe[1:0];
      end
      if (sci_b_en)
      begin
         ovr[`PPEI_PORT_S].own[`PPEI_SCI_B_LSB +: 2] = 2'h3;
         ovr[`PPEI_PORT_S].o[`PPEI_SCI_B_LSB +: 2] = sci_out[3:2];
         ovr[`PPEI_PORT_S].oe[`PPEI_SCI_B_LSB +: 2] = sci_oe[3:2];
      end
      if (spi_a_en && !route_spi_a)
      begin
         ovr[`PPEI_PORT_S].own[`PPEI_SPI_A_LSB +: 4] = 4'hF;
         ovr[`PPEI_PORT_S].o[`PPEI_SPI_A_LSB +: 4] = spi_a_out;
         ovr[`PPEI_PORT_S].oe[`PPEI_SPI_A_LSB +: 4] = spi_a_oe;
      end
      if (spi_a_en && route_spi_a)
      begin
         ovr[`PPEI_PORT_M].own[`PPEI_SPI_A_ALT_LSB +: 4] = 4'hF;
         ovr[`PPEI_PORT_M].o[`PPEI_SPI_A_ALT_LSB +: 4] = spi_a_out;
         ovr[`PPEI_PORT_M].oe[`PPEI_SPI_A_ALT_LSB +: 4] = spi_a_oe;
      end
      if (pwm_en)
      begin
         ovr[`PPEI_PORT_P].own = `PPEI_FULL_MASK;
         ovr[`PPEI_PORT_P].o = pwm_out;
         ovr[`PPEI_PORT_P].oe = `PPEI_FULL_MASK;
         ovr[`PPEI_PORT_P].oe[`PPEI_PWM_IN_BIT] = !pwm7_input;
      end
      else if (spi_b_en && !route_spi_b)
      begin
         ovr[`PPEI_PORT_P].own[`PPEI_SPI_B_LSB +: 4] = 4'hF;
         ovr[`PPEI_PORT_P].o[`PPEI_SPI_B_LSB +: 4] = spi_b_out;
         ovr[`PPEI_PORT_P].oe[`PPEI_SPI_B_LSB +: 4] = spi_b_oe;
      end
      if (spi_b_en && route_spi_b)
      begin
         ovr[`PPEI_PORT_H].own[`PPEI_SPI_B_LSB +: 4] = 4'hF;
         ovr[`PPEI_PORT_H].o[`PPEI_SPI_B_LSB +: 4] = spi_b_out;
         ovr[`PPEI_PORT_H].oe[`PPEI_SPI_B_LSB +: 4] = spi_b_oe;
      end
      if (i2c_en)
      begin
         ovr[`PPEI_PORT_J].own[`PPEI_SCL_BIT] = 1'b1;
         ovr[`PPEI_PORT_J].own[`PPEI_SDA_BIT] = 1'b1;
         ovr[`PPEI_PORT_J].od[`PPEI_SCL_BIT] = 1'b1;
         ovr[`PPEI_PORT_J].od[`PPEI_SDA_BIT] = 1'b1;
         ovr[`PPEI_PORT_J].o[`PPEI_SCL_BIT] = i2c_scl_o;
         ovr[`PPEI_PORT_J].o[`PPEI_SDA_BIT] = i2c_sda_o;
      end
   end

   // Pad control for each port; only the implemented pins of the two-wire port.
   genvar gp;
   generate
      for (gp = 0; gp < `PPEI_NPORT; gp++)
      begin : g_pad
         ppei_pad_ctrl
         #(
            .IMPL  ((gp == `PPEI_PORT_J) ? `PPEI_PORT_J_MASK : `PPEI_FULL_MASK)
         )
         u_pad
         (
            .cfg   (state_q.cfg[gp]),
            .ovr   (ovr[gp]),
            .level (state_q.sync2[gp]),
            .pad   (pad[gp]),
            .rd_io (io_read[gp])
         );
      end
   endgenerate

   // Filters run every bus clock outside stop, and on the oscillator tick in stop.
   assign sample_en = (mode != mode_stop) || state_q.rc_tick;

   genvar gk;
   genvar gb;
   generate
      for (gk = 0; gk < `PPEI_NIRQ; gk++)
      begin : g_irq
         for (gb = 0; gb < 8; gb++)
         begin : g_bit
            if (IRQ_IMPL[gk][gb])
            begin : g_filt
               ppei_glitch_filter u_filt
               (
                  .clk       (clk),
                  .reset     (reset),
                  .sample_en (sample_en),
                  .level     (state_q.sync2[IRQ_PORT[gk]][gb]),
                  .polarity  (state_q.cfg[IRQ_PORT[gk]].polarity[gb]),
                  .edge_o    (edge_hit[gk][gb]),
                  .busy      (busy[gk][gb])
               );
            end
            else
            begin : g_none
               assign edge_hit[gk][gb] = 1'b0;
               assign busy[gk][gb] = 1'b0;
            end
         end
         assign waiting[gk] = busy[gk] & state_q.cfg[IRQ_PORT[gk]].irq_en & ~state_q.flag[gk];
         assign irq[gk] = |(state_q.flag[gk] & state_q.cfg[IRQ_PORT[gk]].irq_en);
      end
   endgenerate

   assign rc_osc_run = (mode == mode_stop) && (|waiting);

   // Next state: synchronisers, configuration, flags and the stop-mode oscillator.
   always_comb
   begin
      state_d = state_q;
      state_d.sync1 = pin_i;
      state_d.sync2 = state_q.sync1;
      for (int p = 0; p < `PPEI_NPORT; p++)
      begin
         if (cfg_wr[p])
         begin
            state_d.cfg[p] = cfg_wdata;
         end
      end
      for (int k = 0; k < `PPEI_NIRQ; k++)
      begin
         state_d.flag[k] = IRQ_IMPL[k] & ((state_q.flag[k] & ~flag_clr[k]) | edge_hit[k]);
      end
      state_d.rc_tick = 1'b0;
      if (rc_osc_run)
      begin
         if (state_q.rc_cnt == `PPEI_RC_DIV - `PPEI_RC_ONE)
         begin
            state_d.rc_cnt = '0;
            state_d.rc_tick = 1'b1;
         end
         else
         begin
            state_d.rc_cnt = state_q.rc_cnt + `PPEI_RC_ONE;
         end
      end
      else
      begin
         state_d.rc_cnt = '0;
      end
   end

   // Reset leaves all ports as inputs, interrupts off, pulls per port.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_q <= '0;
         state_q.cfg[`PPEI_PORT_S].pull_en <= `PPEI_RST_PULL_S;
         state_q.cfg[`PPEI_PORT_J].pull_en <= `PPEI_RST_PULL_J;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign pin_level = state_q.sync2;
   assign flags = state_q.flag;
   assign wake = (|irq) && (mode != mode_run);
   assign spi_a_in = route_spi_a ? state_q.sync2[`PPEI_PORT_M][`PPEI_SPI_A_ALT_LSB +: 4]
                                 : state_q.sync2[`PPEI_PORT_S][`PPEI_SPI_A_LSB +: 4];
   assign spi_b_in = route_spi_b ? state_q.sync2[`PPEI_PORT_H][`PPEI_SPI_B_LSB +: 4]
                                 : state_q.sync2[`PPEI_PORT_P][`PPEI_SPI_B_LSB +: 4];

   AST_RST_SCI_PULLUP: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) && !sci_a_en && !sci_b_en && !spi_a_en
      |-> pad[`PPEI_PORT_S].oe == '0 && pad[`PPEI_PORT_S].pu == `PPEI_FULL_MASK)
      else $error("Serial-comm port not pulled-up input after reset.");
   AST_RST_SPI_HIZ: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) && !spi_a_en |-> pad[`PPEI_PORT_M].oe == '0
      && pad[`PPEI_PORT_M].pu == '0 && pad[`PPEI_PORT_M].pd == '0)
      else $error("Serial-peripheral port not floating after reset.");
   AST_RST_MOD_HIZ: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) && !pwm_en && !spi_b_en |-> pad[`PPEI_PORT_P].oe == '0
      && pad[`PPEI_PORT_P].pu == '0 && pad[`PPEI_PORT_P].pd == '0)
      else $error("Modulator port not floating after reset.");
   AST_RST_SECOND_HIZ: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) && !spi_b_en |-> pad[`PPEI_PORT_H].oe == '0
      && pad[`PPEI_PORT_H].pu == '0 && pad[`PPEI_PORT_H].pd == '0)
      else $error("Second port not floating after reset.");
   AST_RST_TWOWIRE: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) && !i2c_en |-> pad[`PPEI_PORT_J].oe == '0
      && pad[`PPEI_PORT_J].pu == `PPEI_PORT_J_MASK)
      else $error("Two-wire port not pulled-up input after reset.");
   AST_PWM_OUTPUTS: assert property (@(posedge clk) disable iff (reset)
      pwm_en && !pwm7_input |-> pad[`PPEI_PORT_P].oe == `PPEI_FULL_MASK
      && pad[`PPEI_PORT_P].o == pwm_out)
      else $error("Modulator enabled but port not driving its channels.");
   AST_UNIT_B_PINS: assert property (@(posedge clk) disable iff (reset)
      !pwm_en && spi_b_en && !route_spi_b
      |-> pad[`PPEI_PORT_P].oe[`PPEI_SPI_B_LSB +: 4] == spi_b_oe)
      else $error("Unit b does not control shared modulator pins.");
   AST_ROUTE_A: assert property (@(posedge clk) disable iff (reset)
      spi_a_en && route_spi_a && !sci_a_en && !sci_b_en
      |-> pad[`PPEI_PORT_M].oe[`PPEI_SPI_A_ALT_LSB +: 4] == spi_a_oe
      && pad[`PPEI_PORT_S].oe == state_q.cfg[`PPEI_PORT_S].dir)
      else $error("Routed unit a not on alternate pins.");
   AST_I2C_OPEN_DRAIN: assert property (@(posedge clk) disable iff (reset)
      i2c_en && i2c_scl_o |-> !pad[`PPEI_PORT_J].oe[`PPEI_SCL_BIT])
      else $error("Two-wire clock pin driven high.");
   AST_FLAG_SET: assert property (@(posedge clk) disable iff (reset)
      (|edge_hit) |=> (flags & $past(edge_hit)) == $past(edge_hit))
      else $error("Active edge did not set its flag.");
   AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (reset)
      !(|edge_hit) && !(|flag_clr) |=> flags == $past(flags))
      else $error("Flag changed without edge or clear.");
   AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (reset)
      !(|edge_hit) && flag_clr == flags |=> flags == '0)
      else $error("Writing one did not clear the flag.");
   AST_IRQ_RAISE: assert property (@(posedge clk) disable iff (reset)
      edge_hit[`PPEI_IRQ_P] != '0 && !cfg_wr[`PPEI_PORT_P]
      && (edge_hit[`PPEI_IRQ_P] & state_q.cfg[`PPEI_PORT_P].irq_en) != '0
      && flag_clr[`PPEI_IRQ_P] == '0 |=> irq[`PPEI_IRQ_P])
      else $error("Enabled edge did not raise the port request.");
   AST_WAKE: assert property (@(posedge clk) disable iff (reset)
      (|irq) && mode == mode_stop |-> wake)
      else $error("Pending interrupt did not wake from stop.");
   AST_RC_ONLY_STOP: assert property (@(posedge clk) disable iff (reset)
      mode != mode_stop |-> !rc_osc_run && (!state_q.rc_tick || $past(mode) == mode_stop))
      else $error("Stop oscillator running outside stop.");
endmodule
`default_nettype wire

// [tb/ppei_pin_model.sv]
// External circuitry model that drives or senses the port pins.
`timescale 1ns/10ps
`default_nettype none
module ppei_pin_model
(
   // Clock
   input  wire logic                      clk,
   // Pads and external drive
   input  wire ppei_pkg::ppei_pad_s [5:0] pad,
   input  wire logic [5:0][7:0]           ext,
   input  wire logic [5:0][7:0]           ext_drv,
   // Resolved pin levels
   output logic [5:0][7:0]                pin_i
);
   import ppei_pkg::*;
   logic toggle = 1'b0;
   // A floating pin changes every cycle so that no stale level is read.
   always @(posedge clk)
   begin
      toggle <= ~toggle;
   end
   always_comb
   begin
      for (int p = 0; p < 6; p++)
      begin
         for (int b = 0; b < 8; b++)
         begin
            pin_i[p][b] = pad[p].oe[b] ? pad[p].o[b] : ext_drv[p][b] ? ext[p][b] :
                          pad[p].pu[b] ? 1'b1 : pad[p].pd[b] ? 1'b0 : toggle;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/ppei_top_test.sv]
// Self-checking testbench for the port pin edge interrupt block.
`timescale 1ns/10ps
`default_nettype none
`include "ppei_params.svh"
module ppei_top_test;
   import ppei_pkg::*;
   logic                  clk = 1'b0;
   logic                  reset = 1'b1;
   ppei_mode_e            mode = mode_run;
   logic [5:0]            cfg_wr = 6'h00;
   ppei_cfg_s             cfg_wdata = '0;
   logic [2:0][7:0]       flag_clr = '0;
   logic [7:0]            timer_en = 8'h00, timer_out = 8'h00, pwm_out = 8'h00;
   logic [3:0]            sci_out = 4'h0, sci_oe = 4'h0, spi_a_out = 4'h0, spi_a_oe = 4'h0;
   logic [3:0]            spi_b_out = 4'h0, spi_b_oe = 4'h0;
   logic                  sci_a_en = 1'b0, sci_b_en = 1'b0, spi_a_en = 1'b0, spi_b_en = 1'b0;
   logic                  route_spi_a = 1'b0, route_spi_b = 1'b0, pwm_en = 1'b0;
   logic                  pwm7_input = 1'b0, i2c_en = 1'b0, i2c_scl_o = 1'b0, i2c_sda_o = 1'b0;
   logic [5:0][7:0]       ext = '1, ext_drv = '1, pin_i, io_read, pin_level;
   ppei_pad_s [5:0]       pad;
   logic [3:0]            spi_a_in, spi_b_in;
   logic [2:0][7:0]       flags;
   logic [2:0]            irq;
   logic                  wake, rc_osc_run;
   int                    error_cnt = 0, comparisons = 0, cycles = 0;
   ppei_top dut_u
   (
      .clk, .reset, .mode, .cfg_wr, .cfg_wdata, .flag_clr, .route_spi_a, .route_spi_b,
      .timer_en, .timer_out, .sci_a_en, .sci_b_en, .sci_out, .sci_oe, .spi_a_en, .spi_a_out,
      .spi_a_oe, .spi_b_en, .spi_b_out, .spi_b_oe, .pwm_en, .pwm7_input, .pwm_out, .i2c_en,
      .i2c_scl_o, .i2c_sda_o, .pin_i, .pad, .io_read, .pin_level, .spi_a_in, .spi_b_in,
      .flags, .irq, .wake, .rc_osc_run
   );
   ppei_pin_model pins_u (.clk, .pad, .ext, .ext_drv, .pin_i);
   always #2.5 clk = ~clk;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // The run is cut short if a scenario hangs.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         final_report();
      end
   end
   task automatic cfg(input int p, input ppei_cfg_s c);
      @(posedge clk);
      cfg_wdata <= c;
      cfg_wr[p] <= 1'b1;
      @(posedge clk);
      cfg_wr <= 6'h00;
      @(negedge clk);
   endtask
   task automatic clr(input int i, input logic [7:0] v);
      @(posedge clk);
      flag_clr[i] <= v;
      @(posedge clk);
      flag_clr <= '0;
      @(negedge clk);
   endtask
   // Inverts one pin for len cycles, then lets the filter settle.
   task automatic pulse(input int p, input int b, input int len);
      @(posedge clk);
      ext[p][b] <= ~ext[p][b];
      repeat (len) @(posedge clk);
      ext[p][b] <= ~ext[p][b];
      repeat (12) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic reset_state;
      check(pad[`PPEI_PORT_S].pu, 8'hFF);
      check(pad[`PPEI_PORT_M].pu | pad[`PPEI_PORT_M].pd, 8'h00);
      check(pad[`PPEI_PORT_P].pu | pad[`PPEI_PORT_H].pu, 8'h00);
      check(pad[`PPEI_PORT_J].pu, 8'hC3);
      check({pad[0].oe, pad[1].oe, pad[2].oe, pad[3].oe, pad[4].oe, pad[5].oe}, '0);
      check({flags, irq, wake}, '0);
   endtask
   task automatic edge_irq;
      ext[`PPEI_PORT_H] <= 8'h00;
      cfg(`PPEI_PORT_P, 48'h0000_0000_00FF);
      cfg(`PPEI_PORT_H, 48'h0000_00FF_FFFF);
      pulse(`PPEI_PORT_P, 0, 3);
      check(flags[`PPEI_IRQ_P], 8'h00);
      pulse(`PPEI_PORT_P, 0, 4);
      check({flags[`PPEI_IRQ_P], irq[`PPEI_IRQ_P]}, 9'h003);
      pulse(`PPEI_PORT_H, 3, 4);
      check({flags[`PPEI_IRQ_H], irq[`PPEI_IRQ_H], pad[`PPEI_PORT_H].pd}, 17'h011FF);
      clr(`PPEI_IRQ_P, 8'hFE);
      check(flags[`PPEI_IRQ_P], 8'h01);
      clr(`PPEI_IRQ_P, 8'h01);
      check({flags[`PPEI_IRQ_P], irq[`PPEI_IRQ_P]}, 9'h000);
      cfg(`PPEI_PORT_P, 48'h0202_0000_00FF);
      cfg(`PPEI_PORT_P, 48'h0002_0000_00FF);
      check({io_read[`PPEI_PORT_P], pin_level[`PPEI_PORT_P]}, 16'hFDFF);
      repeat (6) @(posedge clk);
      cfg(`PPEI_PORT_P, 48'h0202_0000_00FF);
      repeat (10) @(posedge clk);
      @(negedge clk);
      check({flags[`PPEI_IRQ_P], irq[`PPEI_IRQ_P]}, 9'h005);
      cfg(`PPEI_PORT_P, 48'h0000_0000_0000);
      check({flags[`PPEI_IRQ_P], irq}, 11'h012);
   endtask
   task automatic low_power;
      @(posedge clk);
      mode <= mode_wait;
      @(negedge clk);
      check({wake, rc_osc_run}, 2'h2);
      @(posedge clk);
      mode <= mode_stop;
      @(negedge clk);
      check(wake, 1'b1);
      @(posedge clk);
      mode <= mode_run;
      @(negedge clk);
      check({wake, rc_osc_run}, 2'h0);
      clr(`PPEI_IRQ_H, 8'h08);
      @(posedge clk);
      mode <= mode_stop;
      @(negedge clk);
      check(rc_osc_run, 1'b0);
      @(posedge clk);
      ext[`PPEI_PORT_H][2] <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check(rc_osc_run, 1'b1);
      repeat (24) @(posedge clk);
      @(negedge clk);
      check({flags[`PPEI_IRQ_H], wake, rc_osc_run}, 10'h012);
      @(posedge clk);
      mode <= mode_run;
      ext[`PPEI_PORT_H][2] <= 1'b0;
      @(negedge clk);
   endtask
   task automatic sharing;
      @(posedge clk);
      pwm_en <= 1'b1;
      pwm7_input <= 1'b1;
      spi_b_en <= 1'b1;
      spi_b_oe <= 4'h5;
      i2c_en <= 1'b1;
      i2c_sda_o <= 1'b1;
      @(negedge clk);
      check(pad[`PPEI_PORT_P].oe, 8'h7F);
      check({pad[`PPEI_PORT_J].oe[7:6], pad[`PPEI_PORT_J].o[7:6]}, 4'h8);
      @(posedge clk);
      pwm_en <= 1'b0;
      @(negedge clk);
      check(pad[`PPEI_PORT_P].oe, 8'h05);
      @(posedge clk);
      route_spi_b <= 1'b1;
      @(negedge clk);
      check({pad[`PPEI_PORT_P].oe, pad[`PPEI_PORT_H].oe}, 16'h0005);
      @(posedge clk);
      spi_a_en <= 1'b1;
      route_spi_a <= 1'b1;
      spi_a_oe <= 4'hF;
      spi_a_out <= 4'hA;
      i2c_scl_o <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      check({pad[`PPEI_PORT_M].oe, pad[`PPEI_PORT_M].o}, 16'h3C28);
      check(pad[`PPEI_PORT_J].oe[7:6], 2'h0);
      @(posedge clk);
      @(negedge clk);
      check({spi_a_in, spi_b_in}, 8'hA0);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      reset_state();
      edge_irq();
      low_power();
      sharing();
      final_report();
   end
endmodule
`default_nettype wire
